// ---- common/iowd_pkg.sv ----
// Types used by the watchdog top module
`default_nettype none
package iowd_pkg;
  typedef enum logic [3:0]
  {
    IOWD_IDLE = 4'h1,
    IOWD_COUNT = 4'h2,
    IOWD_NMI = 4'h4,
    IOWD_RESET = 4'h8
  } iowd_state_e;
  typedef logic [7:0] iowd_sec_t;
endpackage : iowd_pkg
`default_nettype wire

// ---- common/iowd_regs.svh ----
// Port addresses, field positions and timing constants of the I/O port watchdog
// Summary of operation
// R01: Timeout port write loads seconds 0..255
// R02: Arm port read enables, starts countdown
// R03: Further arm reads restart the countdown
// R04: Disarm port read stops watchdog, no expiry
// R05: Control bit zero enables expiry NMI
// R06: NMI serviced, bit cleared, then system reset
// R07: Expiry raises NMI if enabled, else reset
`ifndef IOWD_REGS_SVH
`define IOWD_REGS_SVH

`define IOWD_PORT_TIMEOUT 16'h0143
`define IOWD_PORT_ARM 16'h0443
`define IOWD_PORT_DISARM 16'h0043
`define IOWD_PORT_NMICTL 16'h0543
`define IOWD_NMI_EN_BIT 0
`define IOWD_TIMEOUT_RST 8'h00
`define IOWD_NMI_EN_RST 1'b0
`define IOWD_SEC_NS 32'h3B9A_CA00
`define IOWD_CLK_NS 32'h0000_0008
`define IOWD_RESET_PULSE 32'h0000_0010
`define IOWD_MIN_CYCLES 32'h0000_0008

`endif

// ---- common/iowd_tick_if.sv ----
// One-second tick handshake between the watchdog core and its tick generator
`default_nettype none
interface iowd_tick_if;
  logic restart;
  logic tick;
  modport gen (input restart, output tick);
  modport user (output restart, input tick);
endinterface : iowd_tick_if
`default_nettype wire

// ---- rtl/iowd_tick_gen.sv ----
// Divider that turns the system clock into a one-second tick
`include "iowd_regs.svh"
`default_nettype none
module iowd_tick_gen #(
  parameter int unsigned TICK_CYCLES = `IOWD_SEC_NS / `IOWD_CLK_NS
) (
  input wire logic clk,
  input wire logic rst,
  iowd_tick_if.gen tk
);
  localparam int unsigned W = $clog2(TICK_CYCLES);

  generate
    if (TICK_CYCLES < `IOWD_MIN_CYCLES)
    begin : g_bad
      $error("iowd_tick_gen: TICK_CYCLES too small");
    end
  endgenerate

  logic [W-1:0] div_q;
  logic tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // Restart realigns the second so a refresh always buys a full second
  always_ff @(posedge clk)
  begin
    if (rst || tk.restart)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else if (div_q == W'(TICK_CYCLES - 1))
    begin
      div_q <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + W'(1);
      tick_q <= 1'b0;
    end
  end

  assign tk.tick = tick_q;

  ////////////////////////////////////////////////////////////////////////////
  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    tick_q |=> !tick_q [*7])
    else $error("tick pulses too close together");
endmodule : iowd_tick_gen
`default_nettype wire

// ---- rtl/iowd_top.sv ----
// I/O port watchdog: port decode, countdown, NMI and system reset sequencing
`include "iowd_regs.svh"
`default_nettype none
module iowd_top #(
  parameter int unsigned TICK_CYCLES = `IOWD_SEC_NS / `IOWD_CLK_NS,
  parameter int unsigned RESET_CYCLES = `IOWD_RESET_PULSE
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] ioAddr,
  input wire logic ioWrStb,
  input wire logic ioRdStb,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  output logic wdArmed,
  output logic nmiOut,
  output logic sysResetOut
);
  localparam int unsigned PW = $clog2(RESET_CYCLES + 1);

  generate
    if (RESET_CYCLES < `IOWD_MIN_CYCLES)
    begin : g_bad
      $error("iowd_top: RESET_CYCLES too small");
    end
  endgenerate

  function automatic logic hits(input logic [15:0] a, input logic [15:0] port);
    hits = (a == port);
  endfunction : hits

  ////////////////////////////////////////////////////////////////////////////
  // Port decode; the host is logic on this clock, so strobes are used as is
  logic wrTimeout;
  logic wrNmiCtl;
  logic rdArm;
  logic rdDisarm;

  assign wrTimeout = ioWrStb && hits(ioAddr, `IOWD_PORT_TIMEOUT);
  assign wrNmiCtl = ioWrStb && hits(ioAddr, `IOWD_PORT_NMICTL);
  assign rdArm = ioRdStb && hits(ioAddr, `IOWD_PORT_ARM);
  assign rdDisarm = ioRdStb && hits(ioAddr, `IOWD_PORT_DISARM);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  iowd_pkg::iowd_sec_t timeout_q;
  logic nmiEn_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      timeout_q <= `IOWD_TIMEOUT_RST;
    else if (wrTimeout)
      timeout_q <= ioWrData; // [R01]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      nmiEn_q <= `IOWD_NMI_EN_RST;
    else if (wrNmiCtl)
      nmiEn_q <= ioWrData[`IOWD_NMI_EN_BIT]; // [R05]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick generator
  iowd_tick_if tk ();
  iowd_pkg::iowd_state_e state_q;
  iowd_pkg::iowd_state_e state_d;
  iowd_pkg::iowd_sec_t cnt_q;
  logic [PW-1:0] pulse_q;
  logic expire;
  logic pulseDone;

  // Arm and refresh both realign the second boundary
  assign tk.restart = rdArm && (state_q == iowd_pkg::IOWD_IDLE
                                || state_q == iowd_pkg::IOWD_COUNT);

  iowd_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tk(tk)
  );

  // A count of one or zero ends on this tick, so a timeout of 0 lasts one second
  assign expire = tk.tick && (cnt_q <= 8'h01);
  assign pulseDone = (pulse_q == PW'(RESET_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; disarm beats refresh, refresh beats expiry in the same cycle
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      iowd_pkg::IOWD_IDLE:
      begin
        if (rdArm)
          state_d = iowd_pkg::IOWD_COUNT; // [R02]
      end
      iowd_pkg::IOWD_COUNT:
      begin
        if (rdDisarm)
          state_d = iowd_pkg::IOWD_IDLE; // [R04]
        else if (rdArm)
          state_d = iowd_pkg::IOWD_COUNT; // [R03]
        else if (expire)
          state_d = nmiEn_q ? iowd_pkg::IOWD_NMI : iowd_pkg::IOWD_RESET; // [R07]
      end
      iowd_pkg::IOWD_NMI:
      begin
        if (rdDisarm)
          state_d = iowd_pkg::IOWD_IDLE; // [R04]
        else if (wrNmiCtl && !ioWrData[`IOWD_NMI_EN_BIT])
          state_d = iowd_pkg::IOWD_RESET; // [R06]
      end
      iowd_pkg::IOWD_RESET:
      begin
        if (pulseDone)
          state_d = iowd_pkg::IOWD_IDLE;
      end
      default:
        state_d = iowd_pkg::IOWD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= iowd_pkg::IOWD_IDLE;
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Countdown in seconds
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= `IOWD_TIMEOUT_RST;
    else if (tk.restart)
      cnt_q <= timeout_q; // [R02] [R03]
    else if (state_q == iowd_pkg::IOWD_COUNT && tk.tick && cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end

  // Reset pulse length; the pulse must outlast any reset filter downstream
  always_ff @(posedge clk)
  begin
    if (rst || state_q != iowd_pkg::IOWD_RESET)
      pulse_q <= '0;
    else if (!pulseDone)
      pulse_q <= pulse_q + PW'(1);
  end

  // Read data shows the seconds still left, captured on any read strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      ioRdData <= `IOWD_TIMEOUT_RST;
    else if (ioRdStb)
      ioRdData <= cnt_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wdArmed <= 1'b0;
      nmiOut <= 1'b0;
      sysResetOut <= 1'b0;
    end
    else
    begin
      wdArmed <= (state_d == iowd_pkg::IOWD_COUNT);
      nmiOut <= (state_d == iowd_pkg::IOWD_NMI); // [R07]
      sysResetOut <= (state_d == iowd_pkg::IOWD_RESET); // [R06] [R07]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_timeout_load: assert property ( // [R01]
    wrTimeout |=> timeout_q == $past(ioWrData))
    else $error("timeout byte not loaded");

  a_arm_starts: assert property ( // [R02]
    state_q == iowd_pkg::IOWD_IDLE && rdArm
      |=> state_q == iowd_pkg::IOWD_COUNT && wdArmed && cnt_q == $past(timeout_q))
    else $error("arm read did not start countdown");

  a_refresh_reload: assert property ( // [R03]
    state_q == iowd_pkg::IOWD_COUNT && rdArm && !rdDisarm
      |=> state_q == iowd_pkg::IOWD_COUNT && cnt_q == $past(timeout_q))
    else $error("refresh did not reload countdown");

  a_disarm_stops: assert property ( // [R04]
    rdDisarm && state_q != iowd_pkg::IOWD_RESET
      |=> !wdArmed && !nmiOut && !sysResetOut)
    else $error("disarm read did not stop watchdog");

  a_nmi_bit: assert property ( // [R05]
    wrNmiCtl |=> nmiEn_q == $past(ioWrData[`IOWD_NMI_EN_BIT]))
    else $error("interrupt enable bit not stored");

  a_nmi_clear: assert property ( // [R06]
    state_q == iowd_pkg::IOWD_NMI && wrNmiCtl && !ioWrData[`IOWD_NMI_EN_BIT]
      && !rdDisarm |=> sysResetOut && !nmiOut)
    else $error("cleared enable after NMI gave no reset");

  a_expire_nmi: assert property ( // [R07]
    state_q == iowd_pkg::IOWD_COUNT && expire && nmiEn_q && !ioRdStb
      |=> nmiOut && !sysResetOut)
    else $error("expiry with enable set gave no NMI");

  a_expire_reset: assert property ( // [R07]
    state_q == iowd_pkg::IOWD_COUNT && expire && !nmiEn_q && !ioRdStb
      |=> sysResetOut && !nmiOut)
    else $error("expiry with enable clear gave no reset");

  a_reset_width: assert property ( // [R06] [R07]
    $rose(sysResetOut) |-> sysResetOut [*8])
    else $error("system reset pulse too short");
endmodule : iowd_top
`default_nettype wire

// ---- tb/iowd_host.sv ----
// Host model issuing single-cycle I/O port reads and writes
`default_nettype none
module iowd_host (
  input wire logic clk,
  output logic [15:0] ioAddr,
  output logic ioWrStb,
  output logic ioRdStb,
  output logic [7:0] ioWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ioAddr = 16'h0000;
    ioWrStb = 1'b0;
    ioRdStb = 1'b0;
    ioWrData = 8'h00;
  end
  // Released lines show the inverse so a stale address is never taken for a request
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    ioAddr <= a;
    ioWrData <= d;
    ioWrStb <= wr;
    ioRdStb <= !wr;
    @(posedge clk);
    ioWrStb <= 1'b0;
    ioRdStb <= 1'b0;
    ioAddr <= ~a;
    ioWrData <= ~d;
  endtask : xfer
endmodule : iowd_host
`default_nettype wire

// ---- tb/test_io_port_watchdog_timer.sv ----
// Self-checking bench for the I/O port watchdog
`include "iowd_regs.svh"
`default_nettype none
module test_io_port_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 16;
  localparam int RC = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] ioAddr;
  logic ioWrStb;
  logic ioRdStb;
  logic [7:0] ioWrData;
  logic [7:0] ioRdData;
  logic wdArmed;
  logic nmiOut;
  logic sysResetOut;
  int badCount = 0;
  int comparisons = 0;
  int seed = 32'h44ce_ea62;
  int mTo = 0;
  logic mNmi = 1'b0;
  int k;
  always #4 clk = ~clk;
  iowd_top #(.TICK_CYCLES(N), .RESET_CYCLES(RC)) i_dut (.clk(clk), .rst(rst),
    .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioWrData(ioWrData),
    .ioRdData(ioRdData), .wdArmed(wdArmed), .nmiOut(nmiOut), .sysResetOut(sysResetOut));
  iowd_host i_host (.clk(clk), .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
    .ioWrData(ioWrData));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reportAndStop;
    $display("mismatches %0d comparisons %0d", badCount, comparisons);
    if (badCount == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : reportAndStop
  task automatic chkFlag(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask : chkFlag
  // Four-state arguments so an unknown on a data output cannot pass as zero
  task automatic chkCount(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
    end
  endtask : chkCount
  // Model keeps the timeout and the NMI enable; the expiry instant is derived from the timeout
  task automatic regWr(input logic [15:0] a, input logic [7:0] d);
    if (a == `IOWD_PORT_TIMEOUT)
      mTo = d;
    if (a == `IOWD_PORT_NMICTL)
      mNmi = d[`IOWD_NMI_EN_BIT];
    i_host.xfer(1'b1, a, d);
  endtask : regWr
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic waitExp(output int n);
    step();
    n = 1;
    while (wdArmed === 1'b1 && n < 5000)
    begin
      step();
      n++;
    end
    if (n >= 5000)
    begin
      badCount++;
      reportAndStop();
    end
  endtask : waitExp
  task automatic pulse(output int n);
    n = 0;
    while (sysResetOut === 1'b1 && n < 100)
    begin
      n++;
      step();
    end
    if (n >= 100)
    begin
      badCount++;
      reportAndStop();
    end
  endtask : pulse
  // Tick phase is a few cycles loose, so expiry is judged in a small window
  function automatic logic expOk(input int n);
    int e;
    e = (mTo == 0 ? 1 : mTo) * N;
    return n >= e - 3 && n <= e + 3;
  endfunction : expOk
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    step();
    chkFlag("armed after reset", 1'b0, wdArmed);
    chkFlag("reset out after reset", 1'b0, sysResetOut);
    regWr(`IOWD_PORT_NMICTL, {7'($random(seed)), 1'b0});
    regWr(`IOWD_PORT_TIMEOUT, 8'(2 + $unsigned($random(seed)) % 3));
    i_host.xfer(1'b1, 16'h0144, 8'hC8);
    i_host.xfer(1'b0, `IOWD_PORT_ARM, 8'h00);
    waitExp(k);
    chkFlag("expiry time", 1'b1, expOk(k));
    chkFlag("reset on expiry", !mNmi, sysResetOut);
    chkFlag("no nmi when disabled", mNmi, nmiOut);
    pulse(k);
    chkCount("reset pulse", RC, k);
    regWr(`IOWD_PORT_TIMEOUT, 8'h02);
    i_host.xfer(1'b0, `IOWD_PORT_ARM, 8'h00);
    // An immediate refresh reads back the full timeout, no tick has passed yet
    i_host.xfer(1'b0, `IOWD_PORT_ARM, 8'h00);
    step();
    chkCount("seconds left", mTo, ioRdData);
    repeat (3)
    begin
      repeat (N * 3 / 2) step();
      i_host.xfer(1'b0, `IOWD_PORT_ARM, 8'h00);
    end
    step();
    chkFlag("armed after refresh", 1'b1, wdArmed);
    i_host.xfer(1'b0, `IOWD_PORT_DISARM, 8'h00);
    repeat (3 * N) step();
    chkFlag("disarmed", 1'b0, wdArmed);
    chkFlag("no reset after disarm", 1'b0, sysResetOut);
    regWr(`IOWD_PORT_NMICTL, {7'($random(seed)), 1'b1});
    regWr(`IOWD_PORT_TIMEOUT, 8'h00);
    i_host.xfer(1'b0, `IOWD_PORT_ARM, 8'h00);
    waitExp(k);
    chkFlag("zero timeout expiry", 1'b1, expOk(k));
    chkFlag("nmi on expiry", mNmi, nmiOut);
    chkFlag("no reset while nmi", !mNmi, sysResetOut);
    regWr(`IOWD_PORT_NMICTL, 8'h01);
    step();
    chkFlag("nmi kept", 1'b1, nmiOut);
    regWr(`IOWD_PORT_NMICTL, 8'hFE);
    step();
    chkFlag("nmi cleared", 1'b0, nmiOut);
    chkFlag("reset after nmi", 1'b1, sysResetOut);
    pulse(k);
    // The checks above already spent the first cycle of this pulse
    chkCount("reset pulse after nmi", RC, k + 1);
    regWr(`IOWD_PORT_NMICTL, 8'h01);
    i_host.xfer(1'b0, `IOWD_PORT_ARM, 8'h00);
    waitExp(k);
    chkFlag("nmi again", 1'b1, nmiOut);
    i_host.xfer(1'b0, `IOWD_PORT_DISARM, 8'h00);
    step();
    chkFlag("nmi cancelled", 1'b0, nmiOut);
    chkFlag("no reset on cancel", 1'b0, sysResetOut);
    reportAndStop();
  end
endmodule : test_io_port_watchdog_timer
`default_nettype wire
